// *** trap_priority_sequencer.sv ***
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "trap_seq_defines.svh"

// Operation
// - Each cycle take highest pending source first
// - Warning is priority 1; data faults 2
// - Instruction execution traps share priority 3
// - Async sources ordered at priorities 4 to 12
// - Fetch traps 13; illegal/protection 14
// - Priorities 13-14 regenerate; only 13 stores a fetch tag
// - Access fault, timer, trace held in flags
// - Priority 2/3 traps lost with reset/warning
// - Restart raises unaligned trap again internally
// - Warning loads channel regs only if busy
// - Sources classed instruction-caused or asynchronous
// - Resume counter: current at 13/14, next 2/3
// - Async resume counter: first unexecuted instruction
// - Fault counter holds causing instruction address
// - Prefetch fault traps only on execution attempt
// - Channel capture per source class
// - Warning edge-triggered, held four cycles
// - Restart only when valid set, unneeded clear
module trap_priority_sequencer
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic warn_in,
	input wire logic ext_fault_line_a_in,
	input wire logic ext_fault_line_b_in,
	input wire logic ext_irq_line_a_in,
	input wire logic ext_irq_line_b_in,
	input wire logic ext_irq_line_c_in,
	input wire logic ext_irq_line_d_in,
	input wire logic access_fault_in,
	input wire logic timer_expire_in,
	input wire logic trace_set_in,
	input wire logic [2:0] data_trap_in,
	input wire logic [5:0] exec_trap_in,
	input wire logic [31:0] trap_pc_in,
	input wire logic [31:0] trap_next_pc_in,
	input wire logic fetch_fault_in,
	input wire logic [1:0] fetch_code_in,
	input wire logic branch_in,
	input wire logic exec_attempt_in,
	input wire logic illegal_op_in,
	input wire logic prot_viol_in,
	input wire logic [31:0] curr_pc_in,
	input wire logic acc_busy_in,
	input wire logic acc_multiple_in,
	input wire logic [31:0] acc_addr_in,
	input wire logic [31:0] acc_data_in,
	input wire logic [31:0] acc_ctrl_in,
	input wire logic iret_in,
	output logic take_out,
	output logic [3:0] take_prio_out,
	output trap_seq_pkg::cause_t take_cause_out,
	output logic [31:0] resume_counter_out,
	output logic [31:0] fault_instr_counter_out,
	output logic [31:0] chan_addr_out,
	output logic [31:0] chan_data_out,
	output logic [31:0] chan_ctrl_out,
	output logic restart_out
);
	import trap_seq_pkg::*;

	state_t q;
	state_t d;
	logic warn_fire;
	logic [14:1] req;
	logic [3:0] win;
	logic [5:0] ext_lines;

	assign ext_lines = {ext_irq_line_d_in, ext_irq_line_c_in,
		ext_irq_line_b_in, ext_irq_line_a_in, ext_fault_line_b_in,
		ext_fault_line_a_in};

	// ==========================================================
	// Next state
	always_comb
	begin
		d = q;
		d.take = 1'b0;
		d.restart = 1'b0;
		d.bus_wr = 1'b0;
		d.readyout = 1'b1;
		warn_fire = 1'b0;
		win = 4'h0;

		// Register writes land in the data phase
		if (q.bus_wr)
		begin
			unique case ({q.bus_idx, 2'b00})
				`REG_CTRL:
					d.mask = hwdata_in[7:0];
				`REG_FLAGS:
				begin
					if (hwdata_in[`FLAG_ACCESS_FAULT])
						d.access_fault_flag = 1'b0;
					if (hwdata_in[`FLAG_TIMER])
						d.timer_flag = 1'b0;
					if (hwdata_in[`FLAG_TRACE])
						d.trace_pending_flag = 1'b0;
				end
				`REG_CHAN_CTRL:
					d.chan_ctrl = hwdata_in;
				default:
					d.chan_ctrl = d.chan_ctrl;
			endcase
		end

		// Edge seen, then counted while level stays active
		d.warn_prev = warn_in;
		if (warn_in && !q.warn_prev)
			d.warn_cnt = 3'h1;
		else if (warn_in && q.warn_cnt != 3'h0)
		begin
			if (q.warn_cnt == `WARN_HOLD_CYCLES - 3'h1)
			begin
				warn_fire = 1'b1;
				d.warn_cnt = 3'h0;
			end
			else
				d.warn_cnt = q.warn_cnt + 3'h1;
		end
		else
			d.warn_cnt = 3'h0;

		// Fetch fault tag dies on a redirect before execution
		if (branch_in)
			d.fetch_fault = 1'b0;
		else if (fetch_fault_in)
		begin
			d.fetch_fault = 1'b1;
			d.fetch_code = fetch_code_in;
		end

		// Request vector, index equals priority
		req[`PRIO_WARN] = warn_fire;
		req[`PRIO_DATA_MMU] = q.p2_pend;
		req[`PRIO_INST_EXEC] = q.p3_pend | q.ua_pend;
		req[`PRIO_ACCESS_FAULT] = q.access_fault_flag;
		req[10:5] = ext_lines[5:0] & q.mask[5:0];
		req[`PRIO_TIMER] = q.timer_flag & q.mask[6];
		req[`PRIO_TRACE] = q.trace_pending_flag & q.mask[7];
		// Attempt-time only; re-execution brings them back
		req[`PRIO_FETCH] = q.fetch_fault & exec_attempt_in
			& ~branch_in;
		req[`PRIO_DECODE] = exec_attempt_in
			& (illegal_op_in | prot_viol_in);

		for (int i = 14; i >= 1; i--)
		begin
			if (req[i])
				win = 4'(i);
		end

		if (win != 4'h0)
		begin
			d.take = 1'b1;
			d.prio = win;
			// Async default: resume at first unexecuted instruction
			d.resume_counter = curr_pc_in;
		end

		if (win == `PRIO_WARN)
		begin
			d.cause = CAUSE_WARN;
			// Coinciding non-regenerated traps are lost
			d.p2_pend = 1'b0;
			d.p3_pend = 1'b0;
			d.ua_pend = 1'b0;
			if (acc_busy_in)
			begin
				d.chan_addr = acc_addr_in;
				d.chan_data = acc_data_in;
				d.chan_ctrl = acc_ctrl_in;
			end
		end
		else if (win == `PRIO_DATA_MMU || win == `PRIO_INST_EXEC)
		begin
			d.resume_counter = q.inst_next_pc;
			d.fault_instr_counter = q.inst_pc;
			if (win == `PRIO_DATA_MMU)
			begin
				d.p2_pend = 1'b0;
				d.cause = cause_t'(5'(CAUSE_DTLB_USER) + 5'(q.p2_code));
			end
			else if (q.ua_pend)
			begin
				d.ua_pend = 1'b0;
				d.cause = CAUSE_UNALIGNED;
			end
			else
			begin
				d.p3_pend = 1'b0;
				d.cause = cause_t'(5'(CAUSE_UNALIGNED) + 5'(q.p3_code));
			end
		end
		else if (win == `PRIO_ACCESS_FAULT)
		begin
			d.access_fault_flag = 1'b0;
			d.cause = CAUSE_ACCESS_FAULT;
		end
		else if (win >= `PRIO_FAULT_A && win <= `PRIO_TRACE)
		begin
			d.cause = cause_t'(5'(CAUSE_FAULT_A) + 5'(win - `PRIO_FAULT_A));
			if (win == `PRIO_TIMER)
				d.timer_flag = 1'b0;
			if (win == `PRIO_TRACE)
				d.trace_pending_flag = 1'b0;
			// Only an interrupted multiple transfer is recorded
			if (acc_multiple_in)
			begin
				d.chan_addr = acc_addr_in;
				d.chan_data = acc_data_in;
				d.chan_ctrl = acc_ctrl_in;
			end
		end
		else if (win == `PRIO_FETCH)
		begin
			// A tag arriving in the take cycle must survive
			d.fetch_fault = fetch_fault_in;
			d.cause = cause_t'(5'(CAUSE_ITLB_USER) + 5'(q.fetch_code));
			d.fault_instr_counter = curr_pc_in;
		end
		else if (win == `PRIO_DECODE)
		begin
			d.cause = illegal_op_in ? CAUSE_ILLEGAL_OP : CAUSE_PROT_VIOL;
			d.fault_instr_counter = curr_pc_in;
		end

		// New events after the take clears: a set survives, except data/exec events in a warning cycle
		if (!warn_fire)
		begin
			if (data_trap_in != 3'h0)
			begin
				d.p2_pend = 1'b1;
				d.p2_code = data_trap_in[0] ? 2'h0 :
					(data_trap_in[1] ? 2'h1 : 2'h2);
			end
			if (exec_trap_in[5:1] != 5'h00)
			begin
				d.p3_pend = 1'b1;
				d.p3_code = 3'h1;
				for (int j = 5; j >= 1; j--)
				begin
					if (exec_trap_in[j])
						d.p3_code = 3'(j);
				end
			end
			if (exec_trap_in[0])
				d.ua_pend = 1'b1;
			if (data_trap_in != 3'h0 || exec_trap_in != 6'h00)
			begin
				d.inst_pc = trap_pc_in;
				d.inst_next_pc = trap_next_pc_in;
			end
			// Access record for data faults and unaligned access
			if (data_trap_in != 3'h0 || exec_trap_in[0])
			begin
				d.chan_addr = acc_addr_in;
				d.chan_data = acc_data_in;
				d.chan_ctrl = acc_ctrl_in;
			end
		end
		if (access_fault_in)
		begin
			d.access_fault_flag = 1'b1;
			d.chan_addr = acc_addr_in;
			d.chan_data = acc_data_in;
			d.chan_ctrl = acc_ctrl_in;
		end
		if (timer_expire_in)
			d.timer_flag = 1'b1;
		if (trace_set_in)
			d.trace_pending_flag = 1'b1;

		// Interrupt return replays the saved access
		if (iret_in && q.chan_ctrl[`CHC_RESTART_VALID]
			&& !q.chan_ctrl[`CHC_RESULT_UNNEEDED])
		begin
			d.restart = 1'b1;
			if (q.chan_ctrl[`CHC_UNALIGNED])
				d.ua_pend = 1'b1;
		end

		// Address phase; read data built from the updated copy, except status: pending bits from the current request vector, cause and priority from the registered copy
		if (hsel_in && hready_in && htrans_in[1])
		begin
			if (haddr_in[11:5] != 7'h00 || hsize_in != 3'h2)
				d.rdata = 32'h0000_0000;
			else if (hwrite_in)
			begin
				d.bus_wr = 1'b1;
				d.bus_idx = haddr_in[4:2];
			end
			else
			begin
				unique case ({haddr_in[4:2], 2'b00})
					`REG_CTRL:
						d.rdata = {24'h00_0000, d.mask};
					`REG_FLAGS:
						d.rdata = {29'h0000_0000, d.trace_pending_flag,
							d.timer_flag, d.access_fault_flag};
					`REG_STATUS:
						d.rdata = {2'h0, req, 7'h00, 5'(q.cause),
							q.prio};
					`REG_RESUME:
						d.rdata = d.resume_counter;
					`REG_FAULT_PC:
						d.rdata = d.fault_instr_counter;
					`REG_CHAN_ADDR:
						d.rdata = d.chan_addr;
					`REG_CHAN_DATA:
						d.rdata = d.chan_data;
					default:
						d.rdata = d.chan_ctrl;
				endcase
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			q <= '0;
			q.mask <= `CTRL_MASK_RESET;
			q.readyout <= 1'b1;
		end
		else
			q <= d;
	end

	assign hrdata_out = q.rdata;
	assign hreadyout_out = q.readyout;
	assign hresp_out = 1'b0;
	assign take_out = q.take;
	assign take_prio_out = q.prio;
	assign take_cause_out = q.cause;
	assign resume_counter_out = q.resume_counter;
	assign fault_instr_counter_out = q.fault_instr_counter;
	assign chan_addr_out = q.chan_addr;
	assign chan_data_out = q.chan_data;
	assign chan_ctrl_out = q.chan_ctrl;
	assign restart_out = q.restart;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (srst_in);

	property p_warn_edge;
		!warn_in ##1 warn_in [*4] |=> take_out && take_prio_out == 4'h1;
	endproperty
	a_warn_edge: assert property (p_warn_edge)
		else $error("warning not taken after four active cycles");

	property p_warn_once;
		warn_fire ##1 warn_in |-> !warn_fire;
	endproperty
	a_warn_once: assert property (p_warn_once)
		else $error("warning fired twice for one edge");

	property p_data_first;
		q.p2_pend && !warn_fire |=> take_out && take_prio_out == 4'h2;
	endproperty
	a_data_first: assert property (p_data_first)
		else $error("pending data fault not taken next");

	property p_exec_next;
		q.p3_pend && !q.p2_pend && !warn_fire |=>
			take_out && take_prio_out == 4'h3;
	endproperty
	a_exec_next: assert property (p_exec_next)
		else $error("pending execution trap not taken");

	property p_warn_drops;
		warn_fire |=> !q.p2_pend && !q.p3_pend;
	endproperty
	a_warn_drops: assert property (p_warn_drops)
		else $error("data trap survived a warning");

	property p_flag_set_wins;
		access_fault_in |=> q.access_fault_flag;
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins)
		else $error("access fault flag lost");

	property p_decode_resume;
		exec_attempt_in && illegal_op_in && win == 4'hE |=>
			take_out && resume_counter_out == $past(curr_pc_in)
			&& fault_instr_counter_out == $past(curr_pc_in);
	endproperty
	a_decode_resume: assert property (p_decode_resume)
		else $error("decode trap counters wrong");

	property p_async_resume;
		win >= 4'h5 && win <= 4'hC |=>
			resume_counter_out == $past(curr_pc_in);
	endproperty
	a_async_resume: assert property (p_async_resume)
		else $error("async resume counter wrong");

	property p_restart;
		iret_in |=> restart_out == ($past(q.chan_ctrl[31])
			&& !$past(q.chan_ctrl[30]));
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart decision wrong");

	property p_branch_discard;
		branch_in |=> !q.fetch_fault ##0 !(take_out
			&& take_prio_out == 4'hD);
	endproperty
	a_branch_discard: assert property (p_branch_discard)
		else $error("fetch fault kept across a branch");
endmodule

// *** trap_seq_defines.svh ***
`ifndef TRAP_SEQ_DEFINES_SVH
`define TRAP_SEQ_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define REG_CTRL 5'h00
`define REG_FLAGS 5'h04
`define REG_STATUS 5'h08
`define REG_RESUME 5'h0C
`define REG_FAULT_PC 5'h10
`define REG_CHAN_ADDR 5'h14
`define REG_CHAN_DATA 5'h18
`define REG_CHAN_CTRL 5'h1C

// ==========================================================
// Field positions
`define FLAG_ACCESS_FAULT 0
`define FLAG_TIMER 1
`define FLAG_TRACE 2
`define CHC_RESTART_VALID 31
`define CHC_RESULT_UNNEEDED 30
`define CHC_UNALIGNED 29
`define STATUS_PEND_LSB 16

// ==========================================================
// Reset values and timing
`define CTRL_MASK_RESET 8'hFF
`define WARN_HOLD_CYCLES 3'h4

// ==========================================================
// Priority levels
`define PRIO_WARN 4'h1
`define PRIO_DATA_MMU 4'h2
`define PRIO_INST_EXEC 4'h3
`define PRIO_ACCESS_FAULT 4'h4
`define PRIO_FAULT_A 4'h5
`define PRIO_TIMER 4'hB
`define PRIO_TRACE 4'hC
`define PRIO_FETCH 4'hD
`define PRIO_DECODE 4'hE

`endif

// *** trap_seq_pkg.sv ***
package trap_seq_pkg;

	typedef enum logic [4:0]
	{
		CAUSE_NONE, CAUSE_WARN,
		CAUSE_DTLB_USER, CAUSE_DTLB_SUPER, CAUSE_DMMU_PROT,
		CAUSE_UNALIGNED, CAUSE_RANGE, CAUSE_ASSERT, CAUSE_FLOAT,
		CAUSE_MULDIV, CAUSE_EMULATION_TRAP,
		CAUSE_ACCESS_FAULT, CAUSE_FAULT_A, CAUSE_FAULT_B,
		CAUSE_IRQ_A, CAUSE_IRQ_B, CAUSE_IRQ_C, CAUSE_IRQ_D,
		CAUSE_TIMER, CAUSE_TRACE,
		CAUSE_ITLB_USER, CAUSE_ITLB_SUPER, CAUSE_IMMU_PROT,
		CAUSE_IACCESS, CAUSE_ILLEGAL_OP, CAUSE_PROT_VIOL
	} cause_t;

	typedef struct packed
	{
		logic warn_prev;
		logic [2:0] warn_cnt;
		logic p2_pend;
		logic [1:0] p2_code;
		logic p3_pend;
		logic [2:0] p3_code;
		logic ua_pend;
		logic [31:0] inst_pc;
		logic [31:0] inst_next_pc;
		logic access_fault_flag;
		logic timer_flag;
		logic trace_pending_flag;
		logic fetch_fault;
		logic [1:0] fetch_code;
		logic [7:0] mask;
		logic take;
		logic [3:0] prio;
		cause_t cause;
		logic [31:0] resume_counter;
		logic [31:0] fault_instr_counter;
		logic [31:0] chan_addr;
		logic [31:0] chan_data;
		logic [31:0] chan_ctrl;
		logic restart;
		logic bus_wr;
		logic [2:0] bus_idx;
		logic [31:0] rdata;
		logic readyout;
	} state_t;

endpackage

// *** ext_req_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// Far-side request hardware: fault/irq lines and warning
module ext_req_model
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [5:0] raise_in,
	input wire logic warn_go_in,
	input wire logic take_in,
	input wire trap_seq_pkg::cause_t cause_in,
	output logic [5:0] lines_out,
	output logic warn_out
);
	import trap_seq_pkg::*;

	logic [5:0] line_q;
	logic [5:0] clr;
	logic [2:0] wcnt_q;
	// Dropped as soon as the take shows, so no double take
	always_comb
	begin
		for (int i = 0; i < 6; i++)
			clr[i] = take_in && int'(cause_in) == int'(CAUSE_FAULT_A) + i;
		lines_out = line_q & ~clr;
	end
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			line_q <= 6'h00;
			warn_out <= 1'h0;
			wcnt_q <= 3'h0;
		end
		else
		begin
			line_q <= (line_q & ~clr) | raise_in;
			if (warn_go_in)
			begin
				warn_out <= 1'h1;
				wcnt_q <= 3'h4;
			end
			else if (wcnt_q != 3'h0)
			begin
				wcnt_q <= wcnt_q - 3'h1;
				if (wcnt_q == 3'h1)
					warn_out <= 1'h0;
			end
		end
	end
endmodule

// *** trap_priority_sequencer_test.sv ***
`timescale 1ns/100ps
`include "trap_seq_defines.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
$display("wrong value %s exp %h got %h", n, e, g); end end
module trap_priority_sequencer_test;
	import trap_seq_pkg::*;
	logic clk_in = 1'h0, srst_in = 1'h1, hsel_in = 1'h0, hwrite_in = 1'h0;
	logic [1:0] htrans_in = 2'h0, fetch_code_in = 2'h0;
	logic [2:0] hsize_in = 3'h2, data_trap_in = 3'h0;
	logic [5:0] exec_trap_in = 6'h00, raise = 6'h00, lines;
	logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, q;
	logic [31:0] trap_pc_in = 32'h0, trap_next_pc_in = 32'h0;
	logic [31:0] acc_addr_in = 32'h0, curr_pc_in = 32'h1000;
	logic timer_expire_in = 1'h0, fetch_fault_in = 1'h0, branch_in = 1'h0;
	logic exec_attempt_in = 1'h0, illegal_op_in = 1'h0, acc_busy_in = 1'h0;
	logic iret_in = 1'h0, warn_go = 1'h0, warn_in;
	logic access_fault_in = 1'h0, trace_set_in = 1'h0, prot_viol_in = 1'h0;
	logic acc_multiple_in = 1'h0;
	logic hreadyout_out, hresp_out, take_out, restart_out;
	logic [3:0] take_prio_out;
	cause_t take_cause_out;
	logic [31:0] hrdata_out, resume_counter_out, fault_instr_counter_out;
	logic [31:0] chan_addr_out, chan_data_out, chan_ctrl_out;
	int failures = 0, cmp_count = 0, takes = 0, restarts = 0, cycles = 0, n0;
	always #10 clk_in = ~clk_in;
	trap_priority_sequencer uut
	(
		.clk_in(clk_in), .srst_in(srst_in), .hsel_in(hsel_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
		.hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
		.hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
		.hresp_out(hresp_out), .warn_in(warn_in),
		.ext_fault_line_a_in(lines[0]), .ext_fault_line_b_in(lines[1]),
		.ext_irq_line_a_in(lines[2]), .ext_irq_line_b_in(lines[3]),
		.ext_irq_line_c_in(lines[4]), .ext_irq_line_d_in(lines[5]),
		.access_fault_in(access_fault_in),
		.timer_expire_in(timer_expire_in),
		.trace_set_in(trace_set_in), .data_trap_in(data_trap_in),
		.exec_trap_in(exec_trap_in), .trap_pc_in(trap_pc_in),
		.trap_next_pc_in(trap_next_pc_in), .fetch_fault_in(fetch_fault_in),
		.fetch_code_in(fetch_code_in), .branch_in(branch_in),
		.exec_attempt_in(exec_attempt_in), .illegal_op_in(illegal_op_in),
		.prot_viol_in(prot_viol_in), .curr_pc_in(curr_pc_in),
		.acc_busy_in(acc_busy_in), .acc_multiple_in(acc_multiple_in),
		.acc_addr_in(acc_addr_in), .acc_data_in(~acc_addr_in),
		.acc_ctrl_in(acc_addr_in ^ 32'h0000_FFFF), .iret_in(iret_in),
		.take_out(take_out),
		.take_prio_out(take_prio_out), .take_cause_out(take_cause_out),
		.resume_counter_out(resume_counter_out),
		.fault_instr_counter_out(fault_instr_counter_out),
		.chan_addr_out(chan_addr_out), .chan_data_out(chan_data_out),
		.chan_ctrl_out(chan_ctrl_out), .restart_out(restart_out)
	);
	ext_req_model far
	(
		.clk_in(clk_in), .srst_in(srst_in), .raise_in(raise),
		.warn_go_in(warn_go), .take_in(take_out), .cause_in(take_cause_out),
		.lines_out(lines), .warn_out(warn_in)
	);
	// Counted off the edge so registered pulses are settled
	always @(negedge clk_in)
	begin
		if (take_out === 1'h1)
			takes++;
		if (restart_out === 1'h1)
			restarts++;
	end
	task test_done;
	begin
		$display("failures %0d comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			test_done;
		end
	end
	// ==========================================================
	// Bus and event helpers
	function logic [31:0] ra(input logic [4:0] r);
		return {27'h0, r};
	endfunction
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
	begin
		hsel_in <= 1'h1;
		htrans_in <= 2'h2;
		haddr_in <= a;
		hwrite_in <= w;
		hsize_in <= 3'h2;
		@(posedge clk_in);
		while (hreadyout_out !== 1'h1)
			@(posedge clk_in);
		hsel_in <= 1'h0;
		htrans_in <= 2'h0;
		hwdata_in <= d;
		@(posedge clk_in);
		while (hreadyout_out !== 1'h1)
			@(posedge clk_in);
		q = hrdata_out;
	end
	endtask
	task rd(input logic [31:0] a, input logic [31:0] e);
	begin
		xfer(1'h0, a, 32'h0);
		`CHK("read data", e, q)
		`CHK("hresp", 1'h0, hresp_out)
	end
	endtask
	task wait_take(input logic [3:0] p, input cause_t c);
		int n;
	begin
		n = 0;
		// Sampled at the edge: the values of the cycle just ended
		@(posedge clk_in);
		while (take_out !== 1'h1 && n < 30)
		begin
			@(posedge clk_in);
			n++;
		end
		`CHK("take seen", 1'h1, take_out)
		`CHK("take prio", p, take_prio_out)
		`CHK("take cause", c, take_cause_out)
	end
	endtask
	// ==========================================================
	// Scenarios
	initial
	begin
		repeat (12) @(posedge clk_in);
		srst_in <= 1'h0;
		@(posedge clk_in);
		rd(ra(`REG_CTRL), {24'h0, `CTRL_MASK_RESET});
		rd(32'h0000_0100, 32'h0);
		raise <= 6'h04;
		@(posedge clk_in);
		raise <= 6'h00;
		wait_take(4'h7, CAUSE_IRQ_A);
		`CHK("resume", curr_pc_in, resume_counter_out)
		raise <= 6'h09;
		@(posedge clk_in);
		raise <= 6'h00;
		wait_take(`PRIO_FAULT_A, CAUSE_FAULT_A);
		wait_take(4'h8, CAUSE_IRQ_B);
		xfer(1'h1, ra(`REG_CTRL), 32'h0);
		n0 = takes;
		timer_expire_in <= 1'h1;
		raise <= 6'h10;
		@(posedge clk_in);
		timer_expire_in <= 1'h0;
		raise <= 6'h00;
		repeat (5) @(posedge clk_in);
		`CHK("masked takes", n0, takes)
		rd(ra(`REG_FLAGS), 32'h2);
		xfer(1'h1, ra(`REG_CTRL), 32'hFF);
		wait_take(4'h9, CAUSE_IRQ_C);
		wait_take(`PRIO_TIMER, CAUSE_TIMER);
		rd(ra(`REG_FLAGS), 32'h0);
		// Fault and trace set in the cycle the flag clear lands
		fork
			xfer(1'h1, ra(`REG_FLAGS), 32'h1);
			begin
				@(posedge clk_in);
				access_fault_in <= 1'h1;
				trace_set_in <= 1'h1;
				acc_addr_in <= 32'hD000_0100;
				@(posedge clk_in);
				access_fault_in <= 1'h0;
				trace_set_in <= 1'h0;
				acc_addr_in <= 32'hF000_0300;
				acc_multiple_in <= 1'h1;
			end
		join
		wait_take(`PRIO_ACCESS_FAULT, CAUSE_ACCESS_FAULT);
		`CHK("chan addr", 32'hD000_0100, chan_addr_out)
		wait_take(`PRIO_TRACE, CAUSE_TRACE);
		`CHK("chan addr", 32'hF000_0300, chan_addr_out)
		`CHK("chan data", ~32'hF000_0300, chan_data_out)
		`CHK("chan ctrl", 32'hF000_FCFF, chan_ctrl_out)
		acc_multiple_in <= 1'h0;
		acc_addr_in <= 32'hA000_0040;
		trap_pc_in <= 32'h2000;
		trap_next_pc_in <= 32'h2004;
		data_trap_in <= 3'h1;
		@(posedge clk_in);
		data_trap_in <= 3'h0;
		wait_take(`PRIO_DATA_MMU, CAUSE_DTLB_USER);
		`CHK("resume", 32'h2004, resume_counter_out)
		`CHK("chan addr", 32'hA000_0040, chan_addr_out)
		exec_trap_in <= 6'h02;
		@(posedge clk_in);
		exec_trap_in <= 6'h00;
		wait_take(`PRIO_INST_EXEC, CAUSE_RANGE);
		`CHK("fault pc", 32'h2000, fault_instr_counter_out)
		`CHK("resume", 32'h2004, resume_counter_out)
		n0 = takes;
		fetch_fault_in <= 1'h1;
		fetch_code_in <= 2'h3;
		@(posedge clk_in);
		fetch_fault_in <= 1'h0;
		branch_in <= 1'h1;
		@(posedge clk_in);
		branch_in <= 1'h0;
		exec_attempt_in <= 1'h1;
		@(posedge clk_in);
		exec_attempt_in <= 1'h0;
		repeat (3) @(posedge clk_in);
		`CHK("fetch takes", n0, takes)
		fetch_fault_in <= 1'h1;
		@(posedge clk_in);
		fetch_fault_in <= 1'h0;
		curr_pc_in <= 32'h1100;
		exec_attempt_in <= 1'h1;
		@(posedge clk_in);
		exec_attempt_in <= 1'h0;
		wait_take(`PRIO_FETCH, CAUSE_IACCESS);
		`CHK("resume", 32'h1100, resume_counter_out)
		illegal_op_in <= 1'h1;
		exec_attempt_in <= 1'h1;
		@(posedge clk_in);
		illegal_op_in <= 1'h0;
		exec_attempt_in <= 1'h0;
		wait_take(`PRIO_DECODE, CAUSE_ILLEGAL_OP);
		`CHK("fault pc", 32'h1100, fault_instr_counter_out)
		prot_viol_in <= 1'h1;
		exec_attempt_in <= 1'h1;
		curr_pc_in <= 32'h1104;
		@(posedge clk_in);
		prot_viol_in <= 1'h0;
		exec_attempt_in <= 1'h0;
		wait_take(`PRIO_DECODE, CAUSE_PROT_VIOL);
		`CHK("resume", 32'h1104, resume_counter_out)
		acc_busy_in <= 1'h1;
		acc_addr_in <= 32'hB000_0080;
		warn_go <= 1'h1;
		@(posedge clk_in);
		warn_go <= 1'h0;
		wait_take(`PRIO_WARN, CAUSE_WARN);
		`CHK("chan addr", 32'hB000_0080, chan_addr_out)
		acc_busy_in <= 1'h0;
		acc_addr_in <= 32'hC000_00C0;
		repeat (3) @(posedge clk_in);
		warn_go <= 1'h1;
		@(posedge clk_in);
		warn_go <= 1'h0;
		wait_take(`PRIO_WARN, CAUSE_WARN);
		`CHK("chan addr", 32'hB000_0080, chan_addr_out)
		repeat (4) @(posedge clk_in);
		xfer(1'h1, ra(`REG_CHAN_CTRL), 32'hC000_0000);
		iret_in <= 1'h1;
		@(posedge clk_in);
		iret_in <= 1'h0;
		repeat (3) @(posedge clk_in);
		`CHK("restarts", 0, restarts)
		xfer(1'h1, ra(`REG_CHAN_CTRL), 32'hA000_0000);
		iret_in <= 1'h1;
		@(posedge clk_in);
		iret_in <= 1'h0;
		wait_take(`PRIO_INST_EXEC, CAUSE_UNALIGNED);
		`CHK("restarts", 1, restarts)
		rd(ra(`REG_STATUS), 32'h0000_0053);
		test_done;
	end
endmodule
